// >>> diag_fault_monitor_defines.svh
// Constants for the diagnostic fault monitor: timing, fields, reset values
`ifndef DIAG_FAULT_MONITOR_DEFINES_SVH
`define DIAG_FAULT_MONITOR_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     4
`define CRC_TIME_NS       6000
`define CRC_CYCLES        (`CRC_TIME_NS / `CLK_PERIOD_NS)
`define OSC_DIV_DEFAULT   10000
`define CAP_TEST_NS       100000
`define CAP_RISE_MIN_NS   10000
`define CAP_RISE_MIN_CYC  ((`CAP_RISE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Trigger modes and fixed patterns
// ----------------------------------------------------------------------
`define CRC_MODE_KEY      2'h0
`define CRC_MODE_FRAME    2'h1
`define CRC_MODE_CONT     2'h2
`define OSC_HALT_PATTERN  24'h07DEAD

// ----------------------------------------------------------------------
// Logic flag positions
// ----------------------------------------------------------------------
`define LF_OSC_STOP       0
`define LF_TRIM_STALE     1
`define LF_RESET_SEEN     2
`define LF_THREE_WIRE     3
`define LF_WDT_LATE       4
`define LF_WDT_EARLY      5
`define LF_BG_CRC         6
`define LF_LATCH_MON      7
`define LF_DUAL_CALC      8
`define LF_INVERSE        9
`define LF_TRIM_CRC       10
`define LF_BAD_ACCESS     11
`define LF_LOCKED_WRITE   12
`define LF_SCLK_COUNT     13
`define LF_SLIP_BIT       14
`define LF_SERIAL_CRC     15
`define LF_SLEW_BUSY      16

// ----------------------------------------------------------------------
// Analog flag positions
// ----------------------------------------------------------------------
`define AF_DCDC_POWER     2
`define AF_CAP_MISSING    5
`define AF_DCDC_TEMP      6
`define AF_MAIN_TEMP      7
`define AF_SUPPLY_LSB     8

// ----------------------------------------------------------------------
// Reset values and flag classes
// ----------------------------------------------------------------------
`define LOGIC_FLAGS_RST   17'h00004
`define ANALOG_FLAGS_RST  12'h000
`define LOGIC_STICKY      17'h0FFFD
`define LOGIC_ANY_MASK    17'h0FFFF

`endif

// >>> diag_fault_monitor_pkg.sv
// Types shared by the diagnostic fault monitor
package diag_fault_monitor_pkg;

  typedef enum logic {CRC_IDLE, CRC_RUN} crc_state_e;

  typedef enum logic [1:0] {CAP_IDLE, CAP_DRIVE, CAP_RECOVER} cap_state_e;

  typedef logic [16:0] logic_flags_t;
  typedef logic [11:0] analog_flags_t;

endpackage

// >>> diagnostic_fault_monitor.sv
// Diagnostic monitoring, sticky flag capture and fault pin drive
//
// Overview of operation
// - Background CRC only when locked; lock sets reference
// - Background CRC run lasts six microseconds
// - CRC triggers: key, every frame, continuous
// - Sixteen-bit counter ticks at oscillator over 10000
// - Halted oscillator returns fixed pattern each frame
// - Capacitor test judges regulator rise time
// - Test enable reads one until regulator nominal
// - Writing one reloads sticky flag with fault
// - Trim-stale and slew-busy flags follow their source
// - Summary bits OR flags, logic excludes slew
// - Temperature comparators always on, four trip points
// - Over-temperature sets die flag, pulls fault low when its mask bit is clear
// - Supply comparators off by default; reference needs buffer
// - Each supply node has its own sticky flag
// - Fault pin open drain, low on unmasked fault
// - Fault status bit is inverted pin level
// - Trim-stale, reset and capacitor flags never fault
// - Per-source masks for the maskable fault sources
// - Unmaskable sources other than the clock count always drive the fault pin
// - Serial quiet bit keeps clock count off fault
`timescale 1ns/1ns
`include "diag_fault_monitor_defines.svh"
module diagnostic_fault_monitor
  import diag_fault_monitor_pkg::*;
#(
  parameter int OSC_DIV     = `OSC_DIV_DEFAULT,
  parameter int CAP_TIMEOUT = `CAP_TEST_NS / `CLK_PERIOD_NS
)(
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CFG_LOCKED,
  input  wire logic        I_CRC_KEY,
  input  wire logic        I_FRAME_VALID,
  input  wire logic [1:0]  I_CRC_TRIGGER_MODE,
  input  wire logic [15:0] I_CRC_RESULT,
  input  wire logic        I_OSC_TICK_COUNTER_ENABLE,
  input  wire logic        I_OSC_STOPPED,
  input  wire logic        I_OSC_HALT_MARKER_ENABLE,
  input  wire logic        I_REGULATOR_CAP_TEST_START,
  input  wire logic        I_LDO_AT_TARGET,
  input  wire logic        I_LDO_NOMINAL,
  input  wire logic [16:0] I_LOGIC_FAULT_RAW,
  input  wire logic [4:0]  I_ANALOG_FAULT_RAW,
  input  wire logic [16:0] I_LOGIC_UPDATE,
  input  wire logic [11:0] I_ANALOG_UPDATE,
  input  wire logic [1:0]  I_TEMP_LIMIT_SEL,
  input  wire logic [3:0]  I_MAIN_TEMP_TRIP,
  input  wire logic [3:0]  I_DCDC_TEMP_TRIP,
  input  wire logic [3:0]  I_SUPPLY_CMP_EN,
  input  wire logic        I_REF_BUF_EN,
  input  wire logic [3:0]  I_SUPPLY_OUT_WINDOW,
  input  wire logic [15:0] I_FAULT_MASK,
  input  wire logic        I_SERIAL_CHECK_QUIET,
  input  wire logic        I_FAULT_N_IN,
  output logic             O_CRC_BUSY,
  output logic [15:0]      O_OSC_TICK_COUNTER,
  output logic             O_SDO_OVERRIDE,
  output logic [23:0]      O_SDO_PATTERN,
  output logic             O_REGULATOR_CAP_TEST_START,
  output logic             O_LDO_TEST_DRIVE,
  output logic [16:0]      O_LOGIC_CHECK_FLAGS,
  output logic [11:0]      O_ANALOG_CHECK_FLAGS,
  output logic             O_LOGIC_FLAGS_ANY,
  output logic             O_ANALOG_FLAGS_ANY,
  output logic             O_WATCHDOG_FLAG_ANY,
  output logic             O_FAULT_N_OUT,
  output logic             O_FAULT_N_OE,
  output logic             O_FAULT_PIN_STATUS
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Comparator output for the selected trip point (0:142C .. 3:97C)
  function automatic logic trip_pick(input logic [3:0] trip,
                                     input logic [1:0] sel);
    trip_pick = trip[sel];
  endfunction

  // Sticky flag: a written one reloads with the live fault, else hold/set
  function automatic logic_flags_t sticky_next(input logic_flags_t flags,
                                               input logic_flags_t live,
                                               input logic_flags_t upd);
    sticky_next = (upd & live) | (~upd & (flags | live));
  endfunction

  // ----------------------------------------------------------------------
  // Background CRC
  // ----------------------------------------------------------------------
  crc_state_e  crc_state;
  logic [10:0] crc_count;
  logic [15:0] crc_ref;
  logic        ref_pending;
  logic        lock_seen;
  logic        crc_mismatch;
  logic        crc_trigger;
  logic        lock_rise;

  assign lock_rise = I_CFG_LOCKED & ~lock_seen;

  // Requests while unlocked are dropped, not deferred
  always_comb begin
    crc_trigger = 1'b0;
    case (I_CRC_TRIGGER_MODE)
      `CRC_MODE_KEY:   crc_trigger = I_CRC_KEY;
      `CRC_MODE_FRAME: crc_trigger = I_FRAME_VALID;
      `CRC_MODE_CONT:  crc_trigger = 1'b1;
      default:         crc_trigger = 1'b0;
    endcase
    crc_trigger = crc_trigger & I_CFG_LOCKED;
  end

  // Lock edge tracker
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      lock_seen <= 1'b0;
    end else begin
      lock_seen <= I_CFG_LOCKED;
    end
  end

  // Run timer; the first run after locking becomes the reference
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      crc_state    <= CRC_IDLE;
      crc_count    <= 11'h000;
      crc_ref      <= 16'h0000;
      ref_pending  <= 1'b0;
      crc_mismatch <= 1'b0;
    end else begin
      if (lock_rise) begin
        ref_pending <= 1'b1;
      end
      case (crc_state)
        CRC_IDLE: begin
          crc_count <= 11'h000;
          if (lock_rise || crc_trigger) begin
            crc_state <= CRC_RUN;
          end
        end
        CRC_RUN: begin
          crc_count <= crc_count + 11'h001;
          if (crc_count == 11'(`CRC_CYCLES - 1)) begin
            crc_state <= CRC_IDLE;
            if (ref_pending || lock_rise) begin
              crc_ref     <= I_CRC_RESULT;
              ref_pending <= 1'b0;
            end else begin
              crc_mismatch <= (I_CRC_RESULT != crc_ref);
            end
          end
        end
        default: crc_state <= CRC_IDLE;
      endcase
    end
  end

  // Busy level seen by the host
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_CRC_BUSY <= 1'b0;
    end else begin
      O_CRC_BUSY <= (crc_state == CRC_IDLE) ? (lock_rise | crc_trigger)
                  : (crc_count != 11'(`CRC_CYCLES - 1));
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator diagnostics
  // ----------------------------------------------------------------------
  logic [15:0] prescale;

  // Divider to 25 kHz at the default divide; the count freezes while disabled
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      prescale           <= 16'h0000;
      O_OSC_TICK_COUNTER <= 16'h0000;
    end else if (I_OSC_TICK_COUNTER_ENABLE) begin
      if (prescale == 16'(OSC_DIV - 1)) begin
        prescale           <= 16'h0000;
        O_OSC_TICK_COUNTER <= O_OSC_TICK_COUNTER + 16'h0001;
      end else begin
        prescale <= prescale + 16'h0001;
      end
    end
  end

  // Halt marker replaces serial readback while the oscillator is stopped
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_SDO_OVERRIDE <= 1'b0;
      O_SDO_PATTERN  <= 24'h000000;
    end else begin
      O_SDO_OVERRIDE <= I_OSC_STOPPED & I_OSC_HALT_MARKER_ENABLE;
      O_SDO_PATTERN  <= `OSC_HALT_PATTERN;
    end
  end

  // ----------------------------------------------------------------------
  // Regulator capacitor test
  // ----------------------------------------------------------------------
  cap_state_e  cap_state;
  logic [15:0] cap_count;
  logic        cap_result;

  // A fast rise to target means no capacitor loads the node
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      cap_state                  <= CAP_IDLE;
      cap_count                  <= 16'h0000;
      cap_result                 <= 1'b0;
      O_REGULATOR_CAP_TEST_START <= 1'b0;
      O_LDO_TEST_DRIVE           <= 1'b0;
    end else begin
      case (cap_state)
        CAP_IDLE: begin
          cap_count <= 16'h0000;
          if (I_REGULATOR_CAP_TEST_START) begin
            cap_state                  <= CAP_DRIVE;
            O_REGULATOR_CAP_TEST_START <= 1'b1;
            O_LDO_TEST_DRIVE           <= 1'b1;
          end
        end
        CAP_DRIVE: begin
          cap_count <= cap_count + 16'h0001;
          if (I_LDO_AT_TARGET) begin
            cap_result <= (cap_count < 16'(`CAP_RISE_MIN_CYC));
            cap_state  <= CAP_RECOVER;
            O_LDO_TEST_DRIVE <= 1'b0;
          end else if (cap_count == 16'(CAP_TIMEOUT - 1)) begin
            cap_result <= 1'b0;
            cap_state  <= CAP_RECOVER;
            O_LDO_TEST_DRIVE <= 1'b0;
          end
        end
        CAP_RECOVER: begin
          // Enable bit drops only once the node is back at nominal
          if (I_LDO_NOMINAL) begin
            cap_state                  <= CAP_IDLE;
            O_REGULATOR_CAP_TEST_START <= 1'b0;
          end
        end
        default: begin
          cap_state                  <= CAP_IDLE;
          O_REGULATOR_CAP_TEST_START <= 1'b0;
          O_LDO_TEST_DRIVE           <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Flag capture
  // ----------------------------------------------------------------------
  logic_flags_t  logic_live;
  analog_flags_t analog_live;
  logic_flags_t  next_logic_flags;
  analog_flags_t next_analog_flags;
  logic_flags_t  analog_wide;
  logic [3:0]    supply_live;

  // Supply windows gated by their enables; reference input needs buffer
  assign supply_live = I_SUPPLY_OUT_WINDOW & I_SUPPLY_CMP_EN
                     & {2'h3, I_REF_BUF_EN, 1'b1};

  // Live state of every source, internal ones substituted
  always_comb begin
    logic_live                 = I_LOGIC_FAULT_RAW;
    logic_live[`LF_RESET_SEEN] = 1'b0;
    logic_live[`LF_BG_CRC]     = crc_mismatch;
    analog_live = {supply_live,
                   trip_pick(I_MAIN_TEMP_TRIP, I_TEMP_LIMIT_SEL),
                   trip_pick(I_DCDC_TEMP_TRIP, I_TEMP_LIMIT_SEL),
                   cap_result, I_ANALOG_FAULT_RAW};
  end

  // Sticky reload on written ones; trim-stale and slew-busy follow live
  always_comb begin
    next_logic_flags = sticky_next(O_LOGIC_CHECK_FLAGS, logic_live,
                                   I_LOGIC_UPDATE);
    next_logic_flags = (next_logic_flags & `LOGIC_STICKY)
                     | (logic_live & ~`LOGIC_STICKY);
    analog_wide = sticky_next({5'h00, O_ANALOG_CHECK_FLAGS},
                              {5'h00, analog_live},
                              {5'h00, I_ANALOG_UPDATE});
    next_analog_flags = analog_wide[11:0];
  end

  // Flag registers; reset-seen comes up set after every reset
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_LOGIC_CHECK_FLAGS  <= `LOGIC_FLAGS_RST;
      O_ANALOG_CHECK_FLAGS <= `ANALOG_FLAGS_RST;
    end else begin
      O_LOGIC_CHECK_FLAGS  <= next_logic_flags;
      O_ANALOG_CHECK_FLAGS <= next_analog_flags;
    end
  end

  // Summaries from the next flag values so they align with the flags
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_LOGIC_FLAGS_ANY   <= 1'b1;
      O_ANALOG_FLAGS_ANY  <= 1'b0;
      O_WATCHDOG_FLAG_ANY <= 1'b0;
    end else begin
      O_LOGIC_FLAGS_ANY   <= |(next_logic_flags & `LOGIC_ANY_MASK);
      O_ANALOG_FLAGS_ANY  <= |next_analog_flags;
      O_WATCHDOG_FLAG_ANY <= next_logic_flags[`LF_WDT_LATE]
                           | next_logic_flags[`LF_WDT_EARLY];
    end
  end

  // ----------------------------------------------------------------------
  // Fault pin
  // ----------------------------------------------------------------------
  logic [15:0] maskable;
  logic        fault_fixed;
  logic        fault_now;

  // Trim-stale, reset-seen and capacitor flags are left out
  assign maskable = {next_analog_flags[`AF_MAIN_TEMP],
                     next_analog_flags[`AF_DCDC_TEMP],
                     next_analog_flags[4:3],
                     next_analog_flags[1:0],
                     next_logic_flags[`LF_SERIAL_CRC],
                     next_logic_flags[`LF_SLIP_BIT],
                     next_logic_flags[`LF_LOCKED_WRITE],
                     next_logic_flags[`LF_BAD_ACCESS],
                     next_logic_flags[`LF_INVERSE],
                     next_logic_flags[`LF_DUAL_CALC],
                     next_logic_flags[`LF_LATCH_MON],
                     next_logic_flags[`LF_WDT_LATE],
                     next_logic_flags[`LF_WDT_EARLY],
                     next_logic_flags[`LF_OSC_STOP]};

  assign fault_fixed = next_logic_flags[`LF_THREE_WIRE]
                     | next_logic_flags[`LF_BG_CRC]
                     | next_logic_flags[`LF_TRIM_CRC]
                     | next_analog_flags[`AF_DCDC_POWER]
                     | (|next_analog_flags[11:`AF_SUPPLY_LSB])
                     | (next_logic_flags[`LF_SCLK_COUNT]
                        & ~I_SERIAL_CHECK_QUIET);

  assign fault_now = fault_fixed | (|(maskable & ~I_FAULT_MASK));

  // Open drain: only ever drive low, release to the pull-up otherwise
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_FAULT_N_OUT      <= 1'b0;
      O_FAULT_N_OE       <= 1'b0;
      O_FAULT_PIN_STATUS <= 1'b0;
    end else begin
      O_FAULT_N_OUT      <= 1'b0;
      O_FAULT_N_OE       <= fault_now;
      O_FAULT_PIN_STATUS <= ~I_FAULT_N_IN;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [11:0] crc_run_len;

  // Length of the current busy run, for the duration check
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      crc_run_len <= 12'h000;
    end else begin
      crc_run_len <= O_CRC_BUSY ? crc_run_len + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  crc_unlocked_a: assert property (
    crc_state == CRC_IDLE && !I_CFG_LOCKED |=> crc_state == CRC_IDLE)
    else $error("background CRC started while unlocked");

  crc_length_a: assert property (
    $fell(O_CRC_BUSY) |-> crc_run_len == 12'(`CRC_CYCLES))
    else $error("background CRC run has wrong length");

  halt_pattern_a: assert property (
    I_OSC_STOPPED && I_OSC_HALT_MARKER_ENABLE
    |=> O_SDO_OVERRIDE && O_SDO_PATTERN == `OSC_HALT_PATTERN)
    else $error("halt marker not presented");

  cap_release_a: assert property (
    $fell(O_REGULATOR_CAP_TEST_START) |-> $past(I_LDO_NOMINAL)
    && !O_LDO_TEST_DRIVE)
    else $error("capacitor test ended before regulator recovered");

  sticky_hold_a: assert property (
    ##1 ((O_ANALOG_CHECK_FLAGS | $past(I_ANALOG_UPDATE))
         & $past(O_ANALOG_CHECK_FLAGS)) == $past(O_ANALOG_CHECK_FLAGS))
    else $error("sticky analog flag lost without a write");

  update_reload_a: assert property (
    ##1 (O_LOGIC_CHECK_FLAGS & $past(I_LOGIC_UPDATE) & `LOGIC_STICKY)
    == ($past(logic_live) & $past(I_LOGIC_UPDATE) & `LOGIC_STICKY))
    else $error("written flag not reloaded with live state");

  slew_live_a: assert property (
    ##1 O_LOGIC_CHECK_FLAGS[`LF_SLEW_BUSY]
    == $past(I_LOGIC_FAULT_RAW[`LF_SLEW_BUSY]))
    else $error("slew busy flag not following its source");

  summary_or_a: assert property (
    O_ANALOG_FLAGS_ANY == (|O_ANALOG_CHECK_FLAGS)
    && O_LOGIC_FLAGS_ANY == (|O_LOGIC_CHECK_FLAGS[15:0]))
    else $error("summary bit disagrees with flags");

  temp_fault_a: assert property (
    O_ANALOG_CHECK_FLAGS[`AF_MAIN_TEMP] && !$past(I_FAULT_MASK[15])
    |-> O_FAULT_N_OE)
    else $error("over-temperature did not pull fault low");

  quiet_a: assert property (
    O_FAULT_N_OE |-> $past(fault_fixed) || $past(|(maskable
    & ~I_FAULT_MASK)))
    else $error("fault pin driven with no enabled source");

  never_fault_a: assert property (
    $past(O_LOGIC_CHECK_FLAGS) == `LOGIC_FLAGS_RST
    && O_LOGIC_CHECK_FLAGS == `LOGIC_FLAGS_RST
    && O_ANALOG_CHECK_FLAGS == 12'h000 |-> !O_FAULT_N_OE)
    else $error("reset-seen flag drove the fault pin");

endmodule

// >>> fault_line_model.sv
// Shared open-drain fault line with pull-up and a second device on it
`timescale 1ns/1ns
module fault_line_model (
  input  wire logic i_oe,
  input  wire logic i_out,
  input  wire logic i_other_pull,
  output logic      o_line_n
);
  // Pull-up wins unless some device pulls low; a released line never
  // keeps the last driven value, so a stuck enable cannot hide
  assign o_line_n = ((i_oe && !i_out) || i_other_pull) ? 1'b0 : 1'b1;
endmodule

// >>> diagnostic_fault_monitor_tb.sv
// Self-checking bench for the diagnostic fault monitor
`timescale 1ns/1ns
`include "diag_fault_monitor_defines.svh"
module diagnostic_fault_monitor_tb
  import diag_fault_monitor_pkg::*;
;
  logic I_REF_CLK, I_RST_N, I_CFG_LOCKED, I_CRC_KEY, I_FRAME_VALID;
  logic I_OSC_TICK_COUNTER_ENABLE, I_OSC_STOPPED, I_OSC_HALT_MARKER_ENABLE;
  logic I_REGULATOR_CAP_TEST_START, I_LDO_AT_TARGET, I_LDO_NOMINAL;
  logic I_REF_BUF_EN, I_SERIAL_CHECK_QUIET, I_FAULT_N_IN, other_pull;
  logic [1:0]  I_CRC_TRIGGER_MODE, I_TEMP_LIMIT_SEL;
  logic [3:0]  I_MAIN_TEMP_TRIP, I_DCDC_TEMP_TRIP;
  logic [3:0]  I_SUPPLY_CMP_EN, I_SUPPLY_OUT_WINDOW;
  logic [4:0]  I_ANALOG_FAULT_RAW;
  logic [15:0] I_CRC_RESULT, I_FAULT_MASK, O_OSC_TICK_COUNTER;
  logic [16:0] I_LOGIC_FAULT_RAW, I_LOGIC_UPDATE, O_LOGIC_CHECK_FLAGS;
  logic [11:0] I_ANALOG_UPDATE, O_ANALOG_CHECK_FLAGS;
  logic [23:0] O_SDO_PATTERN;
  logic O_CRC_BUSY, O_SDO_OVERRIDE, O_REGULATOR_CAP_TEST_START;
  logic O_LDO_TEST_DRIVE, O_LOGIC_FLAGS_ANY, O_ANALOG_FLAGS_ANY;
  logic O_WATCHDOG_FLAG_ANY, O_FAULT_N_OUT, O_FAULT_N_OE, O_FAULT_PIN_STATUS;
  logic_flags_t  lf;
  analog_flags_t af;
  logic          oe_x, st_x;
  logic [15:0]   v;
  logic [31:0]   seed = 32'hD99E;
  int            miscompares = 0, n_tests = 0, cyc = 0, lows;

  // Short counts keep the run brief; expectations use the same values
  diagnostic_fault_monitor #(.OSC_DIV(10), .CAP_TIMEOUT(50)) uut (
    .I_REF_CLK, .I_RST_N, .I_CFG_LOCKED, .I_CRC_KEY, .I_FRAME_VALID,
    .I_CRC_TRIGGER_MODE, .I_CRC_RESULT, .I_OSC_TICK_COUNTER_ENABLE,
    .I_OSC_STOPPED, .I_OSC_HALT_MARKER_ENABLE, .I_REGULATOR_CAP_TEST_START,
    .I_LDO_AT_TARGET, .I_LDO_NOMINAL, .I_LOGIC_FAULT_RAW, .I_ANALOG_FAULT_RAW,
    .I_LOGIC_UPDATE, .I_ANALOG_UPDATE, .I_TEMP_LIMIT_SEL, .I_MAIN_TEMP_TRIP,
    .I_DCDC_TEMP_TRIP, .I_SUPPLY_CMP_EN, .I_REF_BUF_EN, .I_SUPPLY_OUT_WINDOW,
    .I_FAULT_MASK, .I_SERIAL_CHECK_QUIET, .I_FAULT_N_IN, .O_CRC_BUSY,
    .O_OSC_TICK_COUNTER, .O_SDO_OVERRIDE, .O_SDO_PATTERN,
    .O_REGULATOR_CAP_TEST_START, .O_LDO_TEST_DRIVE, .O_LOGIC_CHECK_FLAGS,
    .O_ANALOG_CHECK_FLAGS, .O_LOGIC_FLAGS_ANY, .O_ANALOG_FLAGS_ANY,
    .O_WATCHDOG_FLAG_ANY, .O_FAULT_N_OUT, .O_FAULT_N_OE, .O_FAULT_PIN_STATUS);

  fault_line_model fault_line (.i_oe(O_FAULT_N_OE), .i_out(O_FAULT_N_OUT),
    .i_other_pull(other_pull), .o_line_n(I_FAULT_N_IN));

  // Free-running clock, 4 ns period
  initial begin
    I_REF_CLK = 1'b0;
    forever #2 I_REF_CLK = ~I_REF_CLK;
  end

  // Hang guard: about three times the expected run length
  always @(posedge I_REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected pin drive: masked sources, fixed sources, quiet bit
  function automatic logic fault_of(logic_flags_t l, analog_flags_t a,
                                    logic [15:0] m, logic q);
    logic [15:0] src;
    src = {a[7], a[6], a[4], a[3], a[1], a[0], l[15], l[14], l[12], l[11],
           l[9], l[8], l[7], l[4], l[5], l[0]};
    return (|(src & ~m)) | l[3] | l[6] | l[10] | (l[13] & ~q) | a[2]
           | (|a[11:8]);
  endfunction

  task automatic check(input string what, input logic [24:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic quiet();
    {I_LOGIC_FAULT_RAW, I_LOGIC_UPDATE, I_ANALOG_UPDATE} = '0;
    {I_ANALOG_FAULT_RAW, I_FAULT_MASK, I_SERIAL_CHECK_QUIET} = '0;
    {I_TEMP_LIMIT_SEL, I_MAIN_TEMP_TRIP, I_DCDC_TEMP_TRIP} = '0;
    {I_SUPPLY_CMP_EN, I_SUPPLY_OUT_WINDOW, I_REF_BUF_EN, other_pull} = '0;
    {I_CRC_KEY, I_FRAME_VALID, I_CRC_TRIGGER_MODE, I_CFG_LOCKED} = '0;
    {I_REGULATOR_CAP_TEST_START, I_LDO_AT_TARGET, I_LDO_NOMINAL} = '0;
    I_OSC_STOPPED = 1'b0;
  endtask

  // Reset held 6 cycles; outputs are checked while it is held
  task automatic do_reset();
    @(negedge I_REF_CLK);
    I_RST_N = 1'b0;
    quiet();
    repeat (6) @(negedge I_REF_CLK);
    check("reset flags", O_LOGIC_CHECK_FLAGS, `LOGIC_FLAGS_RST);
    check("reset any", {O_LOGIC_FLAGS_ANY, O_FAULT_N_OE}, 2'h2);
    I_RST_N = 1'b1;
    lf = `LOGIC_FLAGS_RST;
    af = '0;
    oe_x = 1'b0;
  endtask

  // Random fault sources, strobes, masks and comparator levels
  task automatic rand_drive();
    logic [31:0] a, b, c;
    @(negedge I_REF_CLK);
    a = xs() & xs() & xs();
    b = xs();
    c = xs() & xs();
    I_LOGIC_FAULT_RAW = a[16:0];
    I_ANALOG_FAULT_RAW = a[21:17];
    I_MAIN_TEMP_TRIP = a[25:22];
    I_DCDC_TEMP_TRIP = a[29:26];
    I_SUPPLY_OUT_WINDOW = c[3:0];
    I_LOGIC_UPDATE = c[20:4];
    I_ANALOG_UPDATE = {c[31:21], a[30]};
    other_pull = a[31];
    I_FAULT_MASK = b[15:0];
    I_SERIAL_CHECK_QUIET = b[16];
    I_TEMP_LIMIT_SEL = b[18:17];
    I_SUPPLY_CMP_EN = b[22:19];
    I_REF_BUF_EN = b[23];
    I_FRAME_VALID = b[24];
    I_CRC_KEY = b[25];
    I_CRC_TRIGGER_MODE = b[27:26];
  endtask

  // One clock of the flag model, then compare every flag-side output
  task automatic step();
    logic_flags_t  live;
    analog_flags_t alive;
    @(posedge I_REF_CLK);
    live = I_LOGIC_FAULT_RAW & ~17'h00044;
    alive = {I_SUPPLY_CMP_EN & I_SUPPLY_OUT_WINDOW & {2'h3, I_REF_BUF_EN, 1'h1},
             I_MAIN_TEMP_TRIP[I_TEMP_LIMIT_SEL],
             I_DCDC_TEMP_TRIP[I_TEMP_LIMIT_SEL], 1'b0, I_ANALOG_FAULT_RAW};
    st_x = oe_x | other_pull;
    lf = (lf & ~I_LOGIC_UPDATE & `LOGIC_STICKY) | live;
    af = (af & ~I_ANALOG_UPDATE) | alive;
    oe_x = fault_of(lf, af, I_FAULT_MASK, I_SERIAL_CHECK_QUIET);
    #1;
    check("logic flags", O_LOGIC_CHECK_FLAGS, lf);
    check("analog flags", O_ANALOG_CHECK_FLAGS, af);
    check("summaries", {O_LOGIC_FLAGS_ANY, O_ANALOG_FLAGS_ANY,
          O_WATCHDOG_FLAG_ANY}, {|lf[15:0], |af, lf[4] | lf[5]});
    check("fault drive", {O_FAULT_N_OE, O_FAULT_N_OUT}, {oe_x, 1'b0});
    check("pin status", O_FAULT_PIN_STATUS, st_x);
    check("crc idle", O_CRC_BUSY, 1'b0);
  endtask

  // Trigger was set at this negedge; follow one run to its end
  task automatic crc_wait(input logic run);
    @(negedge I_REF_CLK);
    I_CRC_KEY = 1'b0;
    I_FRAME_VALID = 1'b0;
    @(negedge I_REF_CLK);
    check("crc start", O_CRC_BUSY, run);
    if (run) begin
      repeat (1498) @(negedge I_REF_CLK);
      check("crc length", O_CRC_BUSY, 1'b1);
      @(negedge I_REF_CLK);
      check("crc end", O_CRC_BUSY, 1'b0);
      @(negedge I_REF_CLK);
    end
  endtask

  // One regulator capacitor test; host stays silent meanwhile
  task automatic cap_run(input logic miss);
    @(negedge I_REF_CLK);
    I_REGULATOR_CAP_TEST_START = 1'b1;
    @(negedge I_REF_CLK);
    I_REGULATOR_CAP_TEST_START = 1'b0;
    @(negedge I_REF_CLK);
    check("cap begin", {O_REGULATOR_CAP_TEST_START, O_LDO_TEST_DRIVE}, 2'h3);
    repeat (miss ? 5 : 55) @(negedge I_REF_CLK);
    I_LDO_AT_TARGET = miss;
    repeat (2) @(negedge I_REF_CLK);
    check("cap drive", {O_REGULATOR_CAP_TEST_START, O_LDO_TEST_DRIVE}, 2'h2);
    I_LDO_NOMINAL = 1'b1;
    repeat (2) @(negedge I_REF_CLK);
    check("cap done", O_REGULATOR_CAP_TEST_START, 1'b0);
    repeat (3) @(negedge I_REF_CLK);
    check("cap flag", O_ANALOG_CHECK_FLAGS[`AF_CAP_MISSING], miss);
    check("cap no fault", O_FAULT_N_OE, 1'b0);
    {I_LDO_AT_TARGET, I_LDO_NOMINAL} = 2'h0;
  endtask

  initial begin
    I_RST_N = 1'b0;
    I_OSC_TICK_COUNTER_ENABLE = 1'b1;
    I_OSC_HALT_MARKER_ENABLE = 1'b1;
    I_CRC_RESULT = 16'h1234;
    quiet();
    do_reset();
    repeat (400) begin
      rand_drive();
      step();
    end
    do_reset();
    cap_run(1'b0);
    cap_run(1'b1);
    // Tick rate and freeze while disabled
    v = O_OSC_TICK_COUNTER;
    repeat (10) @(negedge I_REF_CLK);
    check("tick rate", O_OSC_TICK_COUNTER, v + 16'h0001);
    I_OSC_TICK_COUNTER_ENABLE = 1'b0;
    v = O_OSC_TICK_COUNTER;
    repeat (30) @(negedge I_REF_CLK);
    check("tick frozen", O_OSC_TICK_COUNTER, v);
    I_OSC_TICK_COUNTER_ENABLE = 1'b1;
    // Halted oscillator marker, then marker disabled
    I_OSC_STOPPED = 1'b1;
    repeat (3) @(negedge I_REF_CLK);
    check("halt marker", {O_SDO_OVERRIDE, O_SDO_PATTERN}, 25'h107DEAD);
    I_OSC_HALT_MARKER_ENABLE = 1'b0;
    repeat (3) @(negedge I_REF_CLK);
    check("marker off", O_SDO_OVERRIDE, 1'b0);
    {I_OSC_STOPPED, I_OSC_HALT_MARKER_ENABLE} = 2'h1;
    do_reset();
    // Background check: refused unlocked, reference on lock, each mode
    I_CRC_KEY = 1'b1;
    crc_wait(1'b0);
    I_CFG_LOCKED = 1'b1;
    crc_wait(1'b1);
    I_CRC_KEY = 1'b1;
    crc_wait(1'b1);
    check("crc match", O_LOGIC_CHECK_FLAGS[`LF_BG_CRC], 1'b0);
    {I_CRC_TRIGGER_MODE, I_CRC_KEY, I_FRAME_VALID} = 4'hF;
    crc_wait(1'b0);
    {I_CRC_TRIGGER_MODE, I_CRC_KEY} = 3'h3;
    crc_wait(1'b0);
    I_CRC_RESULT = 16'hBEEF;
    I_FRAME_VALID = 1'b1;
    crc_wait(1'b1);
    check("crc mismatch", {O_LOGIC_CHECK_FLAGS[`LF_BG_CRC], O_FAULT_N_OE},
          2'h3);
    I_CRC_TRIGGER_MODE = 2'h2;
    lows = 0;
    repeat (1700) begin
      @(negedge I_REF_CLK);
      lows += (O_CRC_BUSY === 1'b1) ? 0 : 1;
    end
    check("continuous", (lows >= 1) && (lows <= 4), 1'b1);
    give_verdict();
  end
endmodule
